// ---- op_time_count_monitor.sv ----
// op_time_count_monitor: per-item on-time and rise counters in keep regs
// assumes a classic wishbone master and inputs synchronous to the clock
//
// Behaviour
// - while the monitored bit is 1, add one to time every second
// - on-periods shorter than a whole second earn no time
// - each 0 to 1 change of the bit adds one to the count
// - both counters stop at their maximum instead of wrapping
// - maximum follows each destination's 16 or 32 bit data type
// - values stay until software writes zero to the destination
// - counters are stored only in keep registers
// - reaching a threshold writes 1 to that level's report bit
// - three levels per counter, own threshold and own report bit
// - bits are sampled once per scan; faster pulses may be missed
// - longest scan time is published in ms
// - external communication cycle period is published in ms
// - keep register count is 1024 to 8192; destinations lie inside
// - keep registers survive power loss while the battery lasts
// - project load resets everything except keep storage and the item config memory
// - one to 256 items, each with a time and a count channel
// - a report bit is set once value reaches its threshold and stays set until software clears it
// - the source is any single bit of the monitor input vector
`timescale 1ns/100ps
`include "otc_regs.svh"
module op_time_count_monitor
#(
  parameter int unsigned MS_CYCLES = `OTC_MS_CYCLES // cycles per ms
)
(
  input wire logic CORE_CLK_IN, // 200 MHz clock
  input wire logic SYS_RST_IN, // sync reset, active high
  input wire logic PROJECT_LOAD_IN, // pulse: new project loaded
  input wire logic [255:0] MON_IN, // monitored bit sources
  input wire logic COMM_STROBE_IN, // pulse per external comm cycle
  input wire logic WB_CYC_IN, // wishbone cycle
  input wire logic WB_STB_IN, // wishbone strobe
  input wire logic WB_WE_IN, // wishbone write enable
  input wire logic [15:0] WB_ADR_IN, // wishbone byte address
  input wire logic [3:0] WB_SEL_IN, // wishbone byte selects
  input wire otc_pkg::word_t WB_DAT_IN, // wishbone write data
  output otc_pkg::word_t WB_DAT_OUT, // wishbone read data
  output logic WB_ACK_OUT, // wishbone acknowledge
  output logic SCAN_BUSY_OUT // high while a scan runs
);
  import otc_pkg::*;

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic clr;
  logic ms_tick;
  logic sec_tick;
  logic run;
  logic [8:0] items;
  logic [13:0] keep_n;
  logic [15:0] max_scan;
  logic [15:0] scan_ms;
  logic [15:0] comm_cnt;
  logic [15:0] comm_period;
  eng_e state;
  logic [7:0] item;
  logic ch;
  logic [1:0] k;
  word_t ctl;
  word_t dst;
  word_t val [0:7];
  logic dirty;
  logic sec_pend;
  logic sec_now;
  logic rd_wait;
  logic rd_src;
  logic [255:0] prev;
  logic [255:0] whole;
  logic req;
  logic in_k;
  logic in_c;
  logic bus_k;
  logic bus_c;
  logic bus_r;
  logic bus_w;
  logic commit;
  logic start;
  logic scan_end;
  logic mbit;
  logic credit;
  logic rise;
  logic t_act;
  logic c_act;
  logic [12:0] t_dst;
  logic [12:0] c_dst;
  word_t mx_t;
  word_t mx_c;
  word_t vt;
  word_t vc;
  word_t nt;
  word_t nc;
  word_t reg_rd;
  logic [5:0] hit;

  mem_port_if #(.AW(13)) kp();
  mem_port_if #(.AW(9)) cp();

  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------
  function automatic logic keep_ok(input logic [12:0] a,
                                   input logic [13:0] n,
                                   input logic [1:0] span);
    logic [14:0] s;
    s = {2'b00, a} + {13'h0, span};
    return s < {1'b0, n};
  endfunction : keep_ok

  // counters only ever climb, so only software brings them to zero
  function automatic word_t sat_inc(input word_t v, input word_t mx,
                                    input logic inc);
    return (inc && v != mx) ? v + 32'h1 : v;
  endfunction : sat_inc

  function automatic logic reached(input word_t v, input word_t th,
                                   input word_t mx);
    return v >= (th & mx);
  endfunction : reached

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  assign clr = SYS_RST_IN | PROJECT_LOAD_IN;
  assign req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT & ~rd_wait;
  assign in_k = ~WB_ADR_IN[15] & keep_ok(WB_ADR_IN[14:2], keep_n, 2'h0);
  assign in_c = (WB_ADR_IN[15:14] == 2'b10) & (WB_ADR_IN[13:11] == 3'h0);
  // a commit burst owns the memories so a software clear cannot split it
  assign commit = state == ST_W_T || state == ST_W_C || state == ST_W_CTL;
  assign bus_k = req & in_k & ~commit;
  assign bus_c = req & in_c & ~commit;
  assign bus_r = req & ~in_k & ~in_c;
  assign bus_w = (bus_k | bus_c) & WB_WE_IN;
  assign start = state == ST_IDLE && ms_tick && run;
  assign scan_end = state == ST_W_CTL && {1'b0, item} == items - 9'h001;

  // -----------------------------------------------------------------
  // per-item arithmetic
  // -----------------------------------------------------------------
  // one sample per item visit, so count, time and reports agree
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (state == ST_CHK)
    begin
      mbit <= MON_IN[ctl[`OTC_F_MON +: 8]];
    end
  end
  assign t_dst = dst[12:0];
  assign c_dst = dst[`OTC_F_DST_C +: 13];
  assign t_act = ctl[`OTC_F_EN_T] & keep_ok(t_dst, keep_n, 2'h3);
  assign c_act = ctl[`OTC_F_EN_C] & keep_ok(c_dst, keep_n, 2'h3);
  assign mx_t = ctl[`OTC_F_W32_T] ? `OTC_MAX32 : `OTC_MAX16;
  assign mx_c = ctl[`OTC_F_W32_C] ? `OTC_MAX32 : `OTC_MAX16;
  assign vt = val[0] & mx_t;
  assign vc = val[4] & mx_c;
  // whole: bit seen at every scan since the last second boundary
  assign credit = sec_now & whole[item] & mbit;
  assign rise = mbit & ~prev[item];
  assign nt = sat_inc(vt, mx_t, credit);
  assign nc = sat_inc(vc, mx_c, rise);

  genvar j;
  generate
    for (j = 0; j < 3; j++)
    begin : g_lvl
      assign hit[j] = t_act & reached(nt, val[j + 1], mx_t);
      assign hit[j + 3] = c_act & reached(nc, val[j + 5], mx_c);
    end
  endgenerate

  // -----------------------------------------------------------------
  // memory ports, bus first except during commit
  // -----------------------------------------------------------------
  always_comb
  begin
    kp.en = 1'b0;
    kp.we = 1'b0;
    kp.be = 4'hF;
    kp.addr = (ch ? c_dst : t_dst) + {11'h0, k};
    kp.wdata = WB_DAT_IN;
    if (bus_k)
    begin
      kp.en = 1'b1;
      kp.we = WB_WE_IN;
      kp.be = WB_SEL_IN;
      kp.addr = WB_ADR_IN[14:2];
    end
    else if (state == ST_RD_V)
    begin
      kp.en = 1'b1;
    end
    else if (state == ST_W_T)
    begin
      kp.en = t_act;
      kp.we = 1'b1;
      kp.addr = t_dst;
      kp.wdata = nt;
    end
    else if (state == ST_W_C)
    begin
      kp.en = c_act;
      kp.we = 1'b1;
      kp.addr = c_dst;
      kp.wdata = nc;
    end
  end

  always_comb
  begin
    cp.en = 1'b0;
    cp.we = 1'b0;
    cp.be = 4'hF;
    cp.addr = {item, state == ST_RD_DST};
    cp.wdata = ctl | {10'h0, hit, 16'h0};
    if (bus_c)
    begin
      cp.en = 1'b1;
      cp.we = WB_WE_IN;
      cp.be = WB_SEL_IN;
      cp.addr = WB_ADR_IN[10:2];
      cp.wdata = WB_DAT_IN;
    end
    else if (state == ST_RD_CTL || state == ST_RD_DST)
    begin
      cp.en = 1'b1;
    end
    else if (state == ST_W_CTL)
    begin
      cp.en = 1'b1;
      cp.we = 1'b1;
    end
  end

  word_mem #(.AW(13)) u_keep (.clk_in(CORE_CLK_IN), .p(kp.mem));
  word_mem #(.AW(9)) u_cfg (.clk_in(CORE_CLK_IN), .p(cp.mem));
  tick_gen #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .clk_in(CORE_CLK_IN),
    .rst_in(clr),
    .ms_tick_out(ms_tick),
    .sec_tick_out(sec_tick)
  );

  // -----------------------------------------------------------------
  // scan engine
  // -----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (clr)
    begin
      state <= ST_IDLE;
      item <= 8'h0;
      ch <= 1'b0;
      k <= 2'h0;
      dirty <= 1'b0;
      sec_now <= 1'b0;
      SCAN_BUSY_OUT <= 1'b0;
      ctl <= 32'h0;
      dst <= 32'h0;
    end
    else
    begin
      if (bus_w)
      begin
        dirty <= 1'b1;
      end
      case (state)
        ST_IDLE:
          if (start)
          begin
            state <= ST_RD_CTL;
            item <= 8'h0;
            sec_now <= sec_pend | sec_tick;
            SCAN_BUSY_OUT <= 1'b1;
          end
        ST_RD_CTL:
          if (!bus_c)
          begin
            state <= ST_CAP_CTL;
            dirty <= bus_w;
          end
        ST_CAP_CTL:
        begin
          ctl <= cp.rdata;
          state <= ST_RD_DST;
        end
        ST_RD_DST:
          if (!bus_c)
          begin
            state <= ST_CAP_DST;
          end
        ST_CAP_DST:
        begin
          dst <= cp.rdata;
          ch <= 1'b0;
          state <= ST_CH;
        end
        ST_CH:
          if (ch ? c_act : t_act)
          begin
            k <= 2'h0;
            state <= ST_RD_V;
          end
          else if (!ch)
          begin
            ch <= 1'b1;
          end
          else
          begin
            state <= ST_CHK;
          end
        ST_RD_V:
          if (!bus_k)
          begin
            state <= ST_CAP_V;
          end
        ST_CAP_V:
          if (k != 2'h3)
          begin
            k <= k + 2'h1;
            state <= ST_RD_V;
          end
          else if (!ch)
          begin
            ch <= 1'b1;
            state <= ST_CH;
          end
          else
          begin
            state <= ST_CHK;
          end
        // software touched memory mid-item: reread rather than overwrite
        ST_CHK:
          state <= (dirty | bus_w) ? ST_RD_CTL : ST_W_T;
        ST_W_T:
          state <= ST_W_C;
        ST_W_C:
          state <= ST_W_CTL;
        ST_W_CTL:
          if (scan_end)
          begin
            state <= ST_IDLE;
            SCAN_BUSY_OUT <= 1'b0;
          end
          else
          begin
            item <= item + 8'h1;
            state <= ST_RD_CTL;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // value and threshold words of the current item
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (state == ST_CAP_V)
    begin
      val[{ch, k}] <= kp.rdata;
    end
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (clr)
    begin
      prev <= 256'h0;
      whole <= 256'h0;
    end
    else if (state == ST_W_CTL)
    begin
      prev[item] <= mbit;
      whole[item] <= mbit & (sec_now | whole[item]);
    end
  end

  // a tick landing on the scan start is kept, not lost
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (clr)
    begin
      sec_pend <= 1'b0;
    end
    else
    begin
      sec_pend <= sec_tick | (sec_pend & ~start);
    end
  end

  // -----------------------------------------------------------------
  // published timing: scan length and comm cycle, in ms
  // -----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (clr)
    begin
      scan_ms <= 16'h0;
      max_scan <= 16'h0;
    end
    else
    begin
      if (start)
      begin
        scan_ms <= 16'h0;
      end
      else if (SCAN_BUSY_OUT && ms_tick && scan_ms != 16'hFFFE)
      begin
        scan_ms <= scan_ms + 16'h1;
      end
      if (scan_end && scan_ms + 16'h1 > max_scan)
      begin
        max_scan <= scan_ms + 16'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (clr)
    begin
      comm_cnt <= 16'h0;
      comm_period <= 16'h0;
    end
    else if (COMM_STROBE_IN)
    begin
      comm_period <= comm_cnt;
      comm_cnt <= 16'h0;
    end
    else if (ms_tick && comm_cnt != 16'hFFFF)
    begin
      comm_cnt <= comm_cnt + 16'h1;
    end
  end

  // -----------------------------------------------------------------
  // control registers and bus answer
  // -----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (clr)
    begin
      run <= 1'b0;
      items <= `OTC_RST_ITEMS;
      keep_n <= `OTC_RST_KEEPN;
    end
    else if (bus_r && WB_WE_IN && WB_SEL_IN[1:0] == 2'b11)
    begin
      case (WB_ADR_IN)
        `OTC_A_CTRL:
          run <= WB_DAT_IN[0];
        `OTC_A_ITEMS:
          items <= (WB_DAT_IN == 32'h0) ? `OTC_RST_ITEMS :
                   (WB_DAT_IN > `OTC_ITEMS) ? 9'(`OTC_ITEMS) :
                   WB_DAT_IN[8:0];
        `OTC_A_KEEPN:
          keep_n <= (WB_DAT_IN < `OTC_KEEP_MIN) ? 14'(`OTC_KEEP_MIN) :
                    (WB_DAT_IN > `OTC_KEEP_MAX) ? 14'(`OTC_KEEP_MAX) :
                    WB_DAT_IN[13:0];
        default:
          run <= run;
      endcase
    end
  end

  always_comb
  begin
    case (WB_ADR_IN)
      `OTC_A_CTRL: reg_rd = {31'h0, run};
      `OTC_A_ITEMS: reg_rd = {23'h0, items};
      `OTC_A_KEEPN: reg_rd = {18'h0, keep_n};
      `OTC_A_MAXSCAN: reg_rd = {16'h0, max_scan};
      `OTC_A_COMM: reg_rd = {16'h0, comm_period};
      `OTC_A_STAT: reg_rd = {23'h0, SCAN_BUSY_OUT, item};
      default: reg_rd = 32'h0;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (clr)
    begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0;
      rd_wait <= 1'b0;
      rd_src <= 1'b0;
    end
    else
    begin
      WB_ACK_OUT <= 1'b0;
      rd_wait <= 1'b0;
      if (rd_wait)
      begin
        WB_ACK_OUT <= 1'b1;
        WB_DAT_OUT <= rd_src ? cp.rdata : kp.rdata;
      end
      else if ((bus_k | bus_c) && !WB_WE_IN)
      begin
        rd_wait <= 1'b1;
        rd_src <= bus_c;
      end
      else if (bus_k | bus_c | bus_r)
      begin
        WB_ACK_OUT <= 1'b1;
        WB_DAT_OUT <= reg_rd;
      end
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (clr);

  sequence s_commit;
    state == ST_W_T ##1 state == ST_W_C ##1 state == ST_W_CTL;
  endsequence
  sequence s_rd;
    rd_wait && !WB_ACK_OUT ##1 WB_ACK_OUT;
  endsequence

  property p_time;
    state == ST_W_T && t_act && credit && vt != mx_t |->
      kp.en && kp.wdata == vt + 32'h1;
  endproperty
  a_time: assert property (p_time) else $error("time not +1");
  property p_short;
    state == ST_W_T && t_act && !whole[item] |-> kp.wdata == vt;
  endproperty
  a_short: assert property (p_short) else $error("part second");
  property p_count;
    state == ST_W_C && c_act && rise && vc != mx_c |->
      kp.wdata == vc + 32'h1;
  endproperty
  a_count: assert property (p_count) else $error("count not +1");
  property p_sat;
    state == ST_W_T && t_act && vt == mx_t |-> kp.wdata == mx_t;
  endproperty
  a_sat: assert property (p_sat) else $error("time wrapped");
  property p_type;
    state == ST_W_C && c_act && !ctl[`OTC_F_W32_C] |->
      kp.wdata[31:16] == 16'h0;
  endproperty
  a_type: assert property (p_type) else $error("16-bit overrun");
  property p_commit;
    state == ST_CHK && !(dirty | bus_w) |=> s_commit;
  endproperty
  a_commit: assert property (p_commit) else $error("commit split");
  property p_range;
    kp.en && kp.we && commit |-> {1'b0, kp.addr} < keep_n;
  endproperty
  a_range: assert property (p_range) else $error("dest out");
  property p_level;
    state == ST_W_CTL && t_act && nt >= (val[3] & mx_t) |->
      cp.wdata[`OTC_F_REP + 2];
  endproperty
  a_level: assert property (p_level) else $error("level 3 miss");
  property p_sticky;
    state == ST_W_CTL |->
      (cp.wdata[21:16] & ctl[21:16]) == ctl[21:16];
  endproperty
  a_sticky: assert property (p_sticky) else $error("report lost");
  property p_off;
    state == ST_W_T && !t_act |-> !kp.en;
  endproperty
  a_off: assert property (p_off) else $error("disabled written");
  property p_items;
    SCAN_BUSY_OUT |-> {1'b0, item} < items;
  endproperty
  a_items: assert property (p_items) else $error("item overrun");
  property p_max;
    !clr |=> max_scan >= $past(max_scan);
  endproperty
  a_max: assert property (p_max) else $error("max scan fell");
  property p_rd;
    (bus_k | bus_c) && !WB_WE_IN |=> s_rd;
  endproperty
  a_rd: assert property (p_rd) else $error("read ack late");
endmodule : op_time_count_monitor

// ---- otc_regs.svh ----
// otc_regs.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the monitor design files
`ifndef OTC_REGS_SVH
`define OTC_REGS_SVH
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define OTC_CLK_NS 5
`define OTC_NS_PER_MS 1000000
`define OTC_TICK_MS 1
`define OTC_MS_CYCLES (`OTC_TICK_MS * `OTC_NS_PER_MS / `OTC_CLK_NS)
`define OTC_SEC_MS 1000
// -----------------------------------------------------------------
// sizes and limits
// -----------------------------------------------------------------
`define OTC_ITEMS 256
`define OTC_KEEP_MIN 1024
`define OTC_KEEP_MAX 8192
`define OTC_MAX16 32'h0000FFFF
`define OTC_MAX32 32'hFFFFFFFF
// -----------------------------------------------------------------
// byte addresses
// -----------------------------------------------------------------
`define OTC_A_CTRL 16'hC000
`define OTC_A_ITEMS 16'hC004
`define OTC_A_KEEPN 16'hC008
`define OTC_A_MAXSCAN 16'hC00C
`define OTC_A_COMM 16'hC010
`define OTC_A_STAT 16'hC014
// -----------------------------------------------------------------
// item word 0 / word 1 fields, reset values
// -----------------------------------------------------------------
`define OTC_F_EN_T 0
`define OTC_F_EN_C 1
`define OTC_F_W32_T 2
`define OTC_F_W32_C 3
`define OTC_F_MON 8
`define OTC_F_REP 16
`define OTC_F_DST_C 16
`define OTC_RST_ITEMS 9'h001
`define OTC_RST_KEEPN 14'h0400
`endif

// ---- otc_pkg.sv ----
// otc_pkg: types shared by the monitor design files
// assumes nothing beyond a SystemVerilog compiler
package otc_pkg;
  typedef logic [31:0] word_t;
  typedef enum {
    ST_IDLE, ST_RD_CTL, ST_CAP_CTL, ST_RD_DST, ST_CAP_DST, ST_CH,
    ST_RD_V, ST_CAP_V, ST_CHK, ST_W_T, ST_W_C, ST_W_CTL
  } eng_e;
endpackage : otc_pkg

// ---- mem_port_if.sv ----
// mem_port_if: one single-port memory access path
// assumes the master holds all fields in the cycle en is high
`timescale 1ns/100ps
interface mem_port_if
#(
  parameter int AW = 13 // address width
);
  logic en;
  logic we;
  logic [3:0] be;
  logic [AW-1:0] addr;
  otc_pkg::word_t wdata;
  otc_pkg::word_t rdata;
  modport master (output en, we, be, addr, wdata, input rdata);
  modport mem (input en, we, be, addr, wdata, output rdata);
endinterface : mem_port_if

// ---- word_mem.sv ----
// word_mem: 32-bit word store with byte enables and registered read
// assumes read data is taken the cycle after en with we low
`timescale 1ns/100ps
module word_mem
#(
  parameter int AW = 13 // address width
)
(
  input wire logic clk_in, // core clock
  mem_port_if.mem p // access port
);
  logic [31:0] ram [0:(1 << AW) - 1];

  // no reset: contents ride on the backup supply
  always_ff @(posedge clk_in)
  begin
    if (p.en && p.we)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (p.be[b])
        begin
          ram[p.addr][8*b +: 8] <= p.wdata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (p.en && !p.we)
    begin
      p.rdata <= ram[p.addr];
    end
  end
endmodule : word_mem

// ---- tick_gen.sv ----
// tick_gen: millisecond and one-second enable pulses
// assumes one free-running core clock and a synchronous reset
`timescale 1ns/100ps
`include "otc_regs.svh"
module tick_gen
#(
  parameter int unsigned MS_CYCLES = `OTC_MS_CYCLES // cycles per ms
)
(
  input wire logic clk_in, // core clock
  input wire logic rst_in, // sync reset, active high
  output logic ms_tick_out, // one-cycle pulse per ms
  output logic sec_tick_out // one-cycle pulse per second
);
  logic [31:0] cyc_cnt;
  logic [9:0] ms_cnt;

  always_ff @(posedge clk_in)
  begin
    if (rst_in || cyc_cnt == MS_CYCLES - 1)
    begin
      cyc_cnt <= 32'h0;
    end
    else
    begin
      cyc_cnt <= cyc_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    ms_tick_out <= !rst_in && cyc_cnt == MS_CYCLES - 1;
  end

  // seconds counted in ms pulses, free running
  always_ff @(posedge clk_in)
  begin
    sec_tick_out <= 1'b0;
    if (rst_in)
    begin
      ms_cnt <= 10'h0;
    end
    else if (ms_tick_out)
    begin
      if (ms_cnt == 10'(`OTC_SEC_MS - 1))
      begin
        ms_cnt <= 10'h0;
        sec_tick_out <= 1'b1;
      end
      else
      begin
        ms_cnt <= ms_cnt + 10'h1;
      end
    end
  end
endmodule : tick_gen

// ---- tb_op_time_count_monitor.sv ----
// tb_op_time_count_monitor: wishbone bench for the on-time/rise monitor
// assumes MS_CYCLES of 20, so one second is 20000 clock cycles
`timescale 1ns/100ps
`include "otc_regs.svh"
module tb_op_time_count_monitor;
  import otc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic load = 1'b0;
  logic [255:0] mon = '0;
  logic comm = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  word_t dat = 32'h00000000;
  word_t rdat;
  word_t q;
  logic ack;
  logic busy;
  logic seen_busy = 1'b0;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  op_time_count_monitor #(.MS_CYCLES(20)) dut
  (
    .CORE_CLK_IN(clk),
    .SYS_RST_IN(rst),
    .PROJECT_LOAD_IN(load),
    .MON_IN(mon),
    .COMM_STROBE_IN(comm),
    .WB_CYC_IN(cyc),
    .WB_STB_IN(stb),
    .WB_WE_IN(we),
    .WB_ADR_IN(adr),
    .WB_SEL_IN(4'hF),
    .WB_DAT_IN(dat),
    .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack),
    .SCAN_BUSY_OUT(busy)
  );

  // -----------------------------------------------------------------
  // bus and compare tasks
  // -----------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // memory reads may wait out an engine commit, so no fixed latency
  task xfer(input logic w, input logic [15:0] a, input word_t d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer

  task chk(input logic [15:0] a, input word_t e);
    xfer(1'b0, a, 32'h00000000);
    checks_done++;
    if (q !== e)
    begin
      bad_count++;
      $display("BAD %0t at %h got %h want %h", $time, a, q, e);
    end
  endtask : chk

  task chk_bit(input logic v, input logic e);
    checks_done++;
    if (v !== e)
    begin
      bad_count++;
      $display("BAD %0t flag got %b want %b", $time, v, e);
    end
  endtask : chk_bit

  function automatic logic [15:0] ka(input int i);
    return 16'(i * 4);
  endfunction : ka

  task ms(input int n);
    repeat (n * 20) @(posedge clk);
  endtask : ms

  // -----------------------------------------------------------------
  // comm strobe every 3 ms, busy watch, hang limit
  // -----------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    comm <= (cycles % 60 == 7);
    if (busy === 1'b1)
      seen_busy <= 1'b1;
    if (cycles == 60000)
    begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk(`OTC_A_CTRL, 32'h00000000);
    chk(`OTC_A_ITEMS, 32'h00000001);
    chk(`OTC_A_KEEPN, 32'h00000400);
    chk(16'hF000, 32'h00000000);
    xfer(1'b1, `OTC_A_MAXSCAN, 32'h00000055);
    chk(`OTC_A_MAXSCAN, 32'h00000000);
    xfer(1'b1, `OTC_A_ITEMS, 32'h00000002);
    // value then thresholds 1..3 at dest+1..dest+3
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, ka(16 + i), word_t'(i));
      xfer(1'b1, ka(32 + i), word_t'(i));
      xfer(1'b1, ka(64 + i), 32'h0000FFFF);
    end
    xfer(1'b1, ka(48), 32'h00001234);
    xfer(1'b1, 16'h8000, 32'h00000503);
    xfer(1'b1, 16'h8004, 32'h00200010);
    xfer(1'b1, 16'h8008, 32'h00000502);
    xfer(1'b1, 16'h800C, 32'h00400030);
    xfer(1'b1, `OTC_A_CTRL, 32'h00000001);
    ms(5);
    mon[5] <= 1'b1;
    ms(3);
    mon[5] <= 1'b0;
    ms(3);
    mon[5] <= 1'b1;
    ms(2100);
    mon[5] <= 1'b0;
    ms(3);
    xfer(1'b1, `OTC_A_CTRL, 32'h00000000);
    ms(2);
    chk_bit(busy, 1'b0);
    chk_bit(seen_busy, 1'b1);
    chk(ka(16), 32'h00000001);
    chk(ka(32), 32'h00000002);
    chk(16'h8000, 32'h00190503);
    chk(ka(48), 32'h00001234);
    chk(ka(64), 32'h0000FFFF);
    chk(`OTC_A_COMM, 32'h00000003);
    chk(`OTC_A_MAXSCAN, 32'h00000003);
    xfer(1'b1, ka(32), 32'h00000000);
    chk(ka(32), 32'h00000000);
    xfer(1'b1, ka(1280), 32'h00000005);
    chk(ka(1280), 32'h00000000);
    @(posedge clk);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    chk(`OTC_A_ITEMS, 32'h00000001);
    chk(ka(16), 32'h00000001);
    report_and_stop();
  end
endmodule : tb_op_time_count_monitor
